// ---- pkg/glpc_pkg.sv ----
// Constants and types for the pin level and pack topology register block
package glpc_pkg;

  // Host register access
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam logic [7:0]  ADDR_PIN_LEVEL  = 8'h17;
  localparam logic [7:0]  ADDR_PACK_TOPO  = 8'h18;

  // Multifunction pins
  localparam int          PIN_N           = 4;
  localparam int          OUT_LVL_LSB     = 8;
  localparam int          IN_LVL_LSB      = 0;
  localparam logic [3:0]  OUT_LVL_RESET   = 4'h0;
  localparam logic [3:0]  IN_LVL_RESET    = 4'h0;
  localparam logic [3:0]  I2C_PIN_MASK    = 4'h3;

  // Pack topology fields
  localparam int          FLEX_B_BIT      = 15;
  localparam int          FLEX_A_BIT      = 14;
  localparam int          SCAN_DLY_BIT    = 13;
  localparam int          BLOCK_LSB       = 8;
  localparam int          CELL_B_LSB      = 4;
  localparam int          CELL_A_LSB      = 0;
  localparam int          SEL_W           = 4;
  localparam logic [15:0] PACK_RESET      = 16'hEFFF;
  localparam logic [15:0] PACK_WR_MASK    = 16'hEFFF;
  localparam logic [3:0]  SEL_MIN         = 4'h8;
  localparam logic [3:0]  SEL_MAX         = 4'hE;
  localparam logic [3:0]  SEL_OFF         = 4'hF;

  // Supply multiplexer switches, one per balance-switch pin 8 to 14
  localparam int          SW_N            = 7;
  localparam logic [6:0]  SW_NONE         = 7'h00;
  localparam logic [6:0]  SW_FIRST        = 7'h01;

  // Timing
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          SCAN_DELAY_NS   = 30000;
  localparam int          SCAN_DELAY_CYC  = (SCAN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SCAN_CNT_W      = 10;

  // Highest-cell settle wait
  typedef enum logic [0:0]
  {
    SCAN_IDLE = 1'b0,
    SCAN_WAIT = 1'b1
  } glpc_scan_state_type;

endpackage : glpc_pkg

// ---- pkg/glpc_pair_if.sv ----
// Carrier for one redundant field pair and its agreement flag
`timescale 1ns/1ps
`default_nettype none
interface glpc_pair_if #(parameter int W = 4);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic         agree;

  // Owner supplies the copies, checker answers
  modport src (output a, output b, input agree);
  modport chk (input a, input b, output agree);
endinterface : glpc_pair_if
`default_nettype wire

// ---- verilog/glpc_pair_check.sv ----
// Compare of two redundant copies of a configuration field
`timescale 1ns/1ps
`default_nettype none
module glpc_pair_check #(parameter int W = 4)
(
  // Field pair
  glpc_pair_if.chk pair
);
  import glpc_pkg::*;

  // Purely combinational so a mismatch shows on the very next registered output
  assign pair.agree = (pair.a == pair.b);

endmodule : glpc_pair_check
`default_nettype wire

// ---- verilog/glpc_top.sv ----
// Pin level and pack topology configuration registers with derived mux selections
`timescale 1ns/1ps
`default_nettype none
module glpc_top
(
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // Host register access
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [glpc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [glpc_pkg::DATA_W-1:0]    reg_wdata,
  output logic      [glpc_pkg::DATA_W-1:0]    reg_rdata,
  output logic                                reg_rvalid,
  // Host interface capture points
  input  wire logic                           host_is_uart,
  input  wire logic                           uart_addr_parity_end,
  input  wire logic                           spi_ninth_sclk_rise,
  // Pin mode from the neighbouring configuration register
  input  wire logic [glpc_pkg::PIN_N-1:0]     pin_digital_select,
  input  wire logic [glpc_pkg::PIN_N-1:0]     pin_direction,
  input  wire logic                           i2c_master_select,
  // Multifunction pins
  input  wire logic [glpc_pkg::PIN_N-1:0]     pin_in,
  output logic      [glpc_pkg::PIN_N-1:0]     pin_out,
  output logic      [glpc_pkg::PIN_N-1:0]     pin_oe,
  // Supply and block routing
  output logic                                flexible_pack_active,
  output logic      [glpc_pkg::SW_N-1:0]      supply_pin_mux_sel,
  output logic                                supply_pin_mux_common,
  output logic      [glpc_pkg::SEL_W-1:0]     block_divider_mux,
  output logic      [glpc_pkg::SEL_W-1:0]     balance_switch_alert_top,
  output logic                                balance_switch_alert_mask_en,
  // Measurement scan handshake
  input  wire logic                           alternate_mux_select,
  input  wire logic                           topcell_scan_start,
  output logic                                topcell_sample_go
);
  import glpc_pkg::*;

  localparam int SCAN_GO_TAIL = SCAN_DELAY_CYC - 7; // Strobe delay after eight quiet cycles

  logic [PIN_N-1:0]    out_level_q;
  logic [PIN_N-1:0]    in_level_q;
  logic [DATA_W-1:0]   pack_q;
  logic [PIN_N-1:0]    in_level_d;
  logic [PIN_N-1:0]    in_level_rd;
  logic [PIN_N-1:0]    i2c_mask;
  logic                wr_pin;
  logic                wr_pack;
  logic                capture;
  logic                flex_eff;
  logic                cell_valid;
  logic [SEL_W-1:0]    block_sel;
  logic [SW_N-1:0]     onehot_d;
  logic                scan_dly_need;
  logic [DATA_W-1:0]   rdata_d;
  logic [SCAN_CNT_W-1:0] scan_cnt_q;
  glpc_scan_state_type scan_state_q;

  glpc_pair_if #(.W(1))     enable_pair ();
  glpc_pair_if #(.W(SEL_W)) cell_pair ();

  // Redundant copies handed to the compare units
  assign enable_pair.a = pack_q[FLEX_A_BIT];
  assign enable_pair.b = pack_q[FLEX_B_BIT];
  assign cell_pair.a   = pack_q[CELL_A_LSB +: SEL_W];
  assign cell_pair.b   = pack_q[CELL_B_LSB +: SEL_W];

  glpc_pair_check #(.W(1)) u_enable_check
  (
    .pair (enable_pair.chk)
  );

  glpc_pair_check #(.W(SEL_W)) u_cell_check
  (
    .pair (cell_pair.chk)
  );

  // Address decode
  assign wr_pin  = reg_wr && (reg_addr == ADDR_PIN_LEVEL);
  assign wr_pack = reg_wr && (reg_addr == ADDR_PACK_TOPO);

  // Pins 1:0 belong to the I2C master while it is selected
  assign i2c_mask = i2c_master_select ? I2C_PIN_MASK : '0;

  // Output-level field; stored even when the pin ignores it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      out_level_q <= OUT_LVL_RESET;
    else if (wr_pin)
      out_level_q <= reg_wdata[OUT_LVL_LSB +: PIN_N];
  end

  // Pin drivers: output mode only, and never on pins owned by I2C
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else
    begin
      pin_out <= out_level_q;
      pin_oe  <= pin_digital_select & pin_direction & ~i2c_mask;
    end
  end

  // Analog pins read zero; buffer is watched in both digital directions
  assign in_level_d = pin_in & pin_digital_select & ~i2c_mask;
  assign capture    = host_is_uart ? uart_addr_parity_end : spi_ninth_sclk_rise;

  // Snapshot taken mid-transaction so the reply carries one coherent sample
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      in_level_q <= IN_LVL_RESET;
    else if (capture)
      in_level_q <= in_level_d;
  end

  // Mask again at read time in case I2C was selected after the capture
  assign in_level_rd = in_level_q & ~i2c_mask;

  // Pack topology register; the reserved bit never stores
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pack_q <= PACK_RESET;
    else if (wr_pack)
      pack_q <= reg_wdata & PACK_WR_MASK;
  end

  // Read data; input field is read-only, writes to it are dropped
  always_comb
  begin
    rdata_d = '0;
    if (reg_addr == ADDR_PIN_LEVEL)
    begin
      rdata_d[OUT_LVL_LSB +: PIN_N] = out_level_q;
      rdata_d[IN_LVL_LSB +: PIN_N]  = in_level_rd;
    end
    else if (reg_addr == ADDR_PACK_TOPO)
      rdata_d = pack_q;
  end

  // Read answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_d;
    end
  end

  // A mismatch fails safe toward enabled, never silently off
  assign flex_eff   = enable_pair.agree ? pack_q[FLEX_A_BIT] : 1'b1;
  assign cell_valid = cell_pair.agree && (cell_pair.a >= SEL_MIN) && (cell_pair.a <= SEL_MAX);
  assign onehot_d   = SW_FIRST << 3'(cell_pair.a - SEL_MIN);

  // Supply mux selections, registered from the live fields
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flexible_pack_active  <= 1'b1;
      supply_pin_mux_sel    <= SW_NONE;
      supply_pin_mux_common <= 1'b1;
    end
    else
    begin
      flexible_pack_active <= flex_eff;
      if (!flex_eff)
      begin
        supply_pin_mux_sel    <= SW_NONE;
        supply_pin_mux_common <= 1'b0;
      end
      else if (!enable_pair.agree || !cell_valid)
      begin
        supply_pin_mux_sel    <= SW_NONE;
        supply_pin_mux_common <= 1'b1;
      end
      else
      begin
        supply_pin_mux_sel    <= onehot_d;
        supply_pin_mux_common <= 1'b1;
      end
    end
  end

  // Block divider: unsupported or disabled falls back to the dedicated pin
  assign block_sel = pack_q[BLOCK_LSB +: SEL_W];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      block_divider_mux <= SEL_OFF;
    else if (flex_eff && (block_sel >= SEL_MIN) && (block_sel <= SEL_MAX))
      block_divider_mux <= block_sel;
    else
      block_divider_mux <= SEL_OFF;
  end

  // Alert masking uses the cell field always, whatever the pack enable
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      balance_switch_alert_top     <= SEL_OFF;
      balance_switch_alert_mask_en <= 1'b0;
    end
    else
    begin
      balance_switch_alert_top     <= cell_pair.agree ? cell_pair.a : SEL_OFF;
      balance_switch_alert_mask_en <= cell_pair.agree && (cell_pair.a != SEL_OFF);
    end
  end

  // Settle wait before the highest-cell sample
  assign scan_dly_need = pack_q[SCAN_DLY_BIT] && flex_eff && cell_valid
                         && alternate_mux_select;

  // Starts during a wait are ignored; the scan engine issues one at a time
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scan_state_q      <= SCAN_IDLE;
      scan_cnt_q        <= '0;
      topcell_sample_go <= 1'b0;
    end
    else
    begin
      topcell_sample_go <= 1'b0;
      case (scan_state_q)
        SCAN_IDLE:
        begin
          if (topcell_scan_start && scan_dly_need)
          begin
            scan_cnt_q   <= SCAN_CNT_W'(SCAN_DELAY_CYC - 1);
            scan_state_q <= SCAN_WAIT;
          end
          else if (topcell_scan_start)
            topcell_sample_go <= 1'b1;
        end
        SCAN_WAIT:
        begin
          if (scan_cnt_q == '0)
          begin
            topcell_sample_go <= 1'b1;
            scan_state_q      <= SCAN_IDLE;
          end
          else
            scan_cnt_q <= scan_cnt_q - 1'b1;
        end
        default:
          scan_state_q <= SCAN_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  out_level_a: assert property (
    wr_pin |-> ##2 (pin_out == $past(reg_wdata[OUT_LVL_LSB +: PIN_N], 2)))
    else $error("pin output level does not follow written field");

  drive_gate_a: assert property (
    ##1 ((pin_oe & ~($past(pin_digital_select) & $past(pin_direction))) == '0))
    else $error("pin driven outside digital output mode");

  i2c_pins_a: assert property (
    i2c_master_select |=> (pin_oe[1:0] == 2'b00))
    else $error("I2C pins driven by output level");

  analog_zero_a: assert property (
    capture && !i2c_master_select |=> ((in_level_q & ~$past(pin_digital_select)) == '0))
    else $error("analog pin captured as nonzero");

  uart_capture_a: assert property (
    host_is_uart && uart_addr_parity_end
    |=> (in_level_q == $past(in_level_d)))
    else $error("UART capture missed pin levels");

  spi_capture_a: assert property (
    !host_is_uart && spi_ninth_sclk_rise && !uart_addr_parity_end
    |=> (in_level_q == $past(in_level_d)))
    else $error("SPI capture missed pin levels");

  i2c_read_a: assert property (
    reg_rd && (reg_addr == ADDR_PIN_LEVEL) && i2c_master_select
    |=> reg_rvalid && (reg_rdata[1:0] == 2'b00))
    else $error("I2C input bits read nonzero");

  flex_off_a: assert property (
    enable_pair.agree && !pack_q[FLEX_A_BIT]
    |=> (block_divider_mux == SEL_OFF) && (supply_pin_mux_sel == SW_NONE))
    else $error("disabled flexible pack still routes");

  enable_split_a: assert property (
    pack_q[FLEX_A_BIT] != pack_q[FLEX_B_BIT]
    |=> flexible_pack_active && supply_pin_mux_common && (supply_pin_mux_sel == SW_NONE))
    else $error("enable mismatch not forced to off position");

  cell_select_a: assert property (
    flex_eff && enable_pair.agree && cell_pair.agree && (cell_pair.a == SEL_MIN)
    |=> (supply_pin_mux_sel == SW_FIRST))
    else $error("lowest supported cell not selected");

  cell_split_a: assert property (
    !cell_pair.agree |=> !balance_switch_alert_mask_en && (supply_pin_mux_sel == SW_NONE))
    else $error("cell mismatch still masks or selects");

  block_map_a: assert property (
    (block_sel < SEL_MIN) |=> (block_divider_mux == SEL_OFF))
    else $error("unsupported block selection not mapped");

  scan_wait_a: assert property (
    (scan_state_q == SCAN_IDLE) && topcell_scan_start && scan_dly_need
    |=> !topcell_sample_go [*8] ##[SCAN_GO_TAIL:SCAN_GO_TAIL] topcell_sample_go)
    else $error("highest-cell settle wait wrong length");

  scan_direct_a: assert property (
    (scan_state_q == SCAN_IDLE) && topcell_scan_start && !scan_dly_need
    |=> topcell_sample_go)
    else $error("undelayed sample not issued next cycle");

  pair_follow_a: assert property (
    wr_pack && (reg_wdata[CELL_A_LSB +: SEL_W] != reg_wdata[CELL_B_LSB +: SEL_W])
    |=> ##1 !balance_switch_alert_mask_en)
    else $error("cell mismatch not seen on next cycle");

endmodule : glpc_top
`default_nettype wire

// ---- dv/glpc_pin_model.sv ----
// Pin partner model: external drivers, pull-downs on idle digital pins and a high level on idle analog pins
`timescale 1ns/1ps
`default_nettype none
module glpc_pin_model
(
  // Device side
  input  wire logic [glpc_pkg::PIN_N-1:0] pin_out,
  input  wire logic [glpc_pkg::PIN_N-1:0] pin_oe,
  input  wire logic [glpc_pkg::PIN_N-1:0] pin_digital_select,
  // External side
  input  wire logic [glpc_pkg::PIN_N-1:0] ext_level,
  input  wire logic [glpc_pkg::PIN_N-1:0] ext_en,
  output logic      [glpc_pkg::PIN_N-1:0] pin_in
);
  import glpc_pkg::*;

  // Device driver wins; idle analog pin floats high so missing masking shows
  always_comb
  begin
    for (int i = 0; i < PIN_N; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_level[i];
      else
        pin_in[i] = ~pin_digital_select[i];  // Pull-down on idle digital input
    end
  end
endmodule : glpc_pin_model
`default_nettype wire

// ---- dv/glpc_top_bench.sv ----
// Self-checking bench for the pin level and pack topology registers
`timescale 1ns/1ps
`default_nettype none
module glpc_top_bench;
  import glpc_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst, reg_wr, reg_rd, host_is_uart, uart_pe, spi_r9, i2c, alt, start;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        reg_rvalid, act, com, msk, go;
  logic [3:0]  dsel, dir, pin_in, pin_out, pin_oe, ext_level, ext_en, blk, top;
  logic [6:0]  sel;
  logic [17:0] route;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;

  assign route = {act, sel, com, blk, top, msk};

  glpc_top glpc_top_inst (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .host_is_uart(host_is_uart), .uart_addr_parity_end(uart_pe),
    .spi_ninth_sclk_rise(spi_r9), .pin_digital_select(dsel), .pin_direction(dir),
    .i2c_master_select(i2c), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .flexible_pack_active(act), .supply_pin_mux_sel(sel), .supply_pin_mux_common(com),
    .block_divider_mux(blk), .balance_switch_alert_top(top),
    .balance_switch_alert_mask_en(msk), .alternate_mux_select(alt),
    .topcell_scan_start(start), .topcell_sample_go(go));

  glpc_pin_model glpc_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_digital_select(dsel), .ext_level(ext_level), .ext_en(ext_en), .pin_in(pin_in));

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // Hang guard, far above the roughly 700 cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  // Read strobe, then wait a bounded time for the valid pulse
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] exp);
    int i;
    i = 0;
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    while (reg_rvalid !== 1'b1 && i < 4)
    begin
      @(negedge sys_clk);
      i++;
    end
    chk({nm, " valid"}, 18'h00001, {17'h0, reg_rvalid});
    chk(nm, {2'h0, exp}, {2'h0, reg_rdata});
  endtask : rd

  task automatic strobe(input logic uart);
    @(negedge sys_clk);
    if (uart)
      uart_pe = 1'b1;
    else
      spi_r9 = 1'b1;
    @(negedge sys_clk);
    uart_pe = 1'b0;
    spi_r9 = 1'b0;
  endtask : strobe

  // Reset values of both registers and of the routing they steer
  task automatic t_reset();
    chk("route", {1'h1, 7'h00, 1'h1, 4'hF, 4'hF, 1'h0}, route);
    rd("pin level", 8'h17, 16'h0000);
    rd("pack", 8'h18, 16'hEFFF);
    rd("unmapped", 8'h20, 16'h0000);
  endtask : t_reset

  // Output levels, drive enables and I2C takeover of pins 1:0
  task automatic t_drive();
    wr(8'h17, 16'hFFFF);
    rd("pin level", 8'h17, 16'h0F00);
    dsel = 4'hF;
    dir = 4'h5;
    repeat (2) @(negedge sys_clk);
    chk("oe", 18'h00005, {14'h0, pin_oe});
    chk("out", 18'h00005, {14'h0, pin_out & pin_oe});
    dsel = 4'hB;
    i2c = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("oe i2c", 18'h00000, {14'h0, pin_oe});
    rd("level i2c", 8'h17, 16'h0F00);
    wr(8'h17, 16'h0000);
    rd("cleared", 8'h17, 16'h0000);
  endtask : t_drive

  // Input capture per host type, analog masking and I2C masking
  task automatic t_capture();
    i2c = 1'b0;
    dir = 4'h0;
    ext_en = 4'hF;
    ext_level = 4'hF;
    host_is_uart = 1'b1;
    strobe(1'b0);
    rd("spi ignored", 8'h17, 16'h0000);
    strobe(1'b1);
    rd("uart capture", 8'h17, 16'h000B);
    host_is_uart = 1'b0;
    ext_level = 4'h6;
    strobe(1'b1);
    rd("uart ignored", 8'h17, 16'h000B);
    strobe(1'b0);
    rd("spi capture", 8'h17, 16'h0002);
    i2c = 1'b1;
    ext_level = 4'hF;
    strobe(1'b0);
    rd("i2c capture", 8'h17, 16'h0008);
    i2c = 1'b0;
    wr(8'h17, 16'h08FF);
    dsel = 4'hF;
    dir = 4'h8;
    ext_en = 4'h7;
    ext_level = 4'h0;
    repeat (2) @(negedge sys_clk);
    strobe(1'b0);
    rd("output readback", 8'h17, 16'h0808);
  endtask : t_capture

  // One pack write: routing two edges later, then the stored word
  task automatic pk(input logic [15:0] w, input logic [17:0] exp, input logic [17:0] m);
    wr(8'h18, w);
    @(negedge sys_clk);
    chk("route", exp & m, route & m);
    rd("pack", 8'h18, w & 16'hEFFF);
  endtask : pk

  // Common switch is only judged where the cell selection is off
  task automatic t_pack();
    pk(16'hC9AA, {1'h1, 7'h04, 1'h0, 4'h9, 4'hA, 1'h1}, 18'h3FDFF);
    pk(16'hC588, {1'h1, 7'h01, 1'h0, 4'hF, 4'h8, 1'h1}, 18'h3FDFF);
    pk(16'h4E9A, {1'h1, 7'h00, 1'h1, 4'hE, 4'hF, 1'h0}, 18'h3FFFF);
    pk(16'h0EEE, {1'h0, 7'h00, 1'h0, 4'hF, 4'hE, 1'h1}, 18'h3FFFF);
    pk(16'hCE77, {1'h1, 7'h00, 1'h1, 4'hE, 4'h7, 1'h1}, 18'h3FFFF);
    pk(16'hC8EE, {1'h1, 7'h40, 1'h0, 4'h8, 4'hE, 1'h1}, 18'h3FDFF);
    pk(16'hFFFF, {1'h1, 7'h00, 1'h1, 4'hF, 4'hF, 1'h0}, 18'h3FFFF);
  endtask : t_pack

  // Settle wait before sampling; a restart while waiting must not extend it
  task automatic t_scan(input logic a, input int exp);
    int n;
    n = 0;
    alt = a;
    @(negedge sys_clk);
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    while (go !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
      start = (n == 100 && exp > 1);
    end
    start = 1'b0;
    chk("go delay", 18'(exp), 18'(n));
    @(negedge sys_clk);
    chk("go pulse", 18'h00000, {17'h0, go});
  endtask : t_scan

  initial
  begin
    {rst, reg_wr, reg_rd, host_is_uart, uart_pe, spi_r9, i2c, alt, start} = 9'h100;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    dsel = 4'h0;
    dir = 4'h0;
    ext_level = 4'h0;
    ext_en = 4'h0;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_drive();
    t_capture();
    t_pack();
    wr(8'h18, 16'hE0AA);
    t_scan(1'b1, SCAN_DELAY_CYC);
    t_scan(1'b0, 0);
    summarize();
  end
endmodule : glpc_top_bench
`default_nettype wire
